/* File: bench/tmoc_cnt_model.sv */
// Up-counting timer model feeding count and events to the compare block
`timescale 1ns/100ps
module tmoc_cnt_model
  import tmoc_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             run_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] load_val_in,
  input  wire logic [CNT_W-1:0] top_in,
  output logic      [CNT_W-1:0] count_out = 16'h0000,
  output tmoc_cnt_evt_type      evt_out
);
  logic [1:0] div_ff = 2'h0;
  logic       tick;
  assign tick = run_in && div_ff == 2'h3;
  assign evt_out = '{tick: tick, at_top: count_out == top_in, at_bottom: count_out == 16'h0000,
                     count_write: load_in};
  // Counts up only, loads never land on a downcount
  always @(posedge clk_in)
  begin
    div_ff <= div_ff + 2'h1;
    if (load_in)
      count_out <= load_val_in;
    else if (tick)
      count_out <= evt_out.at_top ? 16'h0000 : count_out + 16'h0001;
  end
endmodule // tmoc_cnt_model

/* File: bench/tmoc_output_compare_sva.sv */
// Port checker for the timer output compare block
`timescale 1ns/100ps
module tmoc_output_compare_sva
  import tmoc_pkg::*;
(
  input wire logic                       clk_sys_in,
  input wire logic                       arst_n_in,
  input wire logic                       reg_wr_in,
  input wire logic [CNT_W-1:0]           count_value_in,
  input wire tmoc_cnt_evt_type           cnt_evt_in,
  input wire logic [CNT_W-1:0]           top_value_out,
  input wire logic                       top_match_out,
  input wire logic [CHANNELS-1:0]        pin_direction_bit_in,
  input wire tmoc_pin_type [CHANNELS-1:0] pin_out,
  input wire logic [CHANNELS-1:0]        channel_output_state_out,
  input wire logic [CHANNELS-1:0]        match_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // Counter write seen, next tick still to come
  logic blk_ff;
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
      blk_ff <= 1'b0;
    else if (cnt_evt_in.count_write)
      blk_ff <= 1'b1;
    else if (cnt_evt_in.tick)
      blk_ff <= 1'b0;
  property p_flag_set;
    cnt_evt_in.tick && !cnt_evt_in.count_write && !blk_ff && count_value_in == top_value_out
      |=> match_flag_out[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match flag A missing");
  property p_block;
    cnt_evt_in.tick && (blk_ff || cnt_evt_in.count_write) |=> !$rose(match_flag_out[0]);
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag A");
  property p_pin_oe;
    pin_out[0].oe == pin_direction_bit_in[0] && pin_out[1].oe == pin_direction_bit_in[1];
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable differs from direction");
  property p_top_match;
    top_match_out == (count_value_in == top_value_out && !blk_ff && !cnt_evt_in.count_write);
  endproperty
  a_top_match: assert property (p_top_match) else $error("top match mismatch");
  property p_rst_state;
    $rose(arst_n_in) |-> channel_output_state_out == 2'b00 ##1 channel_output_state_out == 2'b00;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("output state not cleared");
  property p_flag_cause;
    $rose(match_flag_out[0]) |-> $past(cnt_evt_in.tick);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag A rose without tick");
  property p_top_cause;
    $changed(top_value_out) |-> $past(reg_wr_in || cnt_evt_in.tick);
  endproperty
  a_top_cause: assert property (p_top_cause) else $error("match value changed alone");
  property p_state_cause;
    $changed(channel_output_state_out) |-> $past(reg_wr_in || cnt_evt_in.tick) || $past(reg_wr_in, 2);
  endproperty
  a_state_cause: assert property (p_state_cause) else $error("output state changed alone");
endmodule // tmoc_output_compare_sva

bind tmoc_output_compare tmoc_output_compare_sva u_sva (.clk_sys_in, .arst_n_in, .reg_wr_in,
  .count_value_in, .cnt_evt_in, .top_value_out, .top_match_out, .pin_direction_bit_in, .pin_out,
  .channel_output_state_out, .match_flag_out);

/* File: bench/tmoc_output_compare_tb.sv */
// Testbench for the timer output compare block
`timescale 1ns/100ps
module tmoc_output_compare_tb
  import tmoc_pkg::*;
;
  logic                         clk_sys = 1'b0;
  logic                         arst_n = 1'b0;
  logic [ADDR_W-1:0]            reg_addr = 4'h0;
  logic [DATA_W-1:0]            reg_wdata = 8'h00;
  logic                         reg_wr = 1'b0;
  logic                         reg_rd = 1'b0;
  logic [DATA_W-1:0]            reg_rdata;
  logic [CNT_W-1:0]             count_value;
  logic [CNT_W-1:0]             top_value;
  logic [CNT_W-1:0]             load_val = 16'h0000;
  tmoc_cnt_evt_type             cnt_evt;
  logic                         top_match;
  logic [CHANNELS-1:0]          irq_req;
  logic [CHANNELS-1:0]          irq_ack = 2'b00;
  logic [CHANNELS-1:0]          pin_dir = 2'b00;
  logic [CHANNELS-1:0]          port_val = 2'b00;
  tmoc_pin_type [CHANNELS-1:0]  pin;
  logic [CHANNELS-1:0]          ch_state;
  logic [CHANNELS-1:0]          match_flag;
  logic                         run = 1'b0;
  logic                         load = 1'b0;
  int                           n_fail = 0;
  int                           total_checks = 0;
  logic [1:0]                   acts [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
  logic                         exp_st [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  localparam logic [3:0]        WAVE_PHASE_MATCH = 4'hB;

  always #10 clk_sys = ~clk_sys;

  tmoc_output_compare DUT (.clk_sys_in(clk_sys), .arst_n_in(arst_n), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .count_value_in(count_value), .cnt_evt_in(cnt_evt), .top_value_out(top_value),
    .top_match_out(top_match), .irq_req_out(irq_req), .irq_ack_in(irq_ack),
    .pin_direction_bit_in(pin_dir), .port_value_in(port_val), .pin_out(pin),
    .channel_output_state_out(ch_state), .match_flag_out(match_flag));
  tmoc_cnt_model u_cnt (.clk_in(clk_sys), .run_in(run), .load_in(load), .load_val_in(load_val),
    .top_in(top_value), .count_out(count_value), .evt_out(cnt_evt));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR time %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic limit();
    chk(16'h0000, 16'h0001);
    results();
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  task automatic wr16(input logic [3:0] hi, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(hi - 4'h1, v[7:0]);
  endtask
  task automatic wait_flag(input int ch);
    int k;
    for (k = 0; k < 2000 && match_flag[ch] !== 1'b1; k++)
      @(negedge clk_sys);
    if (k == 2000)
      limit();
  endtask

  task automatic wait_top(input logic [15:0] v);
    int k;
    for (k = 0; k < 400 && top_value !== v; k++)
      @(negedge clk_sys);
    if (k == 400)
      limit();
  endtask

  task automatic s_regs();
    logic [7:0] d;
    settle(1);
    chk({14'h0000, ch_state}, 16'h0000);
    wr16(ADDR_MATCH_A_HIGH, 16'h1234);
    rd(ADDR_MATCH_A_HIGH, d);
    chk({8'h00, d}, 16'h0012);
    wr(ADDR_MATCH_A_HIGH, 8'h56);
    wr(ADDR_MATCH_B_LOW, 8'h78);
    settle(1);
    chk(top_value, 16'h1234);
    rd(ADDR_MATCH_B_HIGH, d);
    chk({8'h00, d}, 16'h0056);
    rd(4'hF, d);
    chk({8'h00, d}, 16'h0000);
    wr16(ADDR_MATCH_A_HIGH, 16'h0010);
    wr16(ADDR_MATCH_B_HIGH, 16'h0005);
    settle(1);
    chk(top_value, 16'h0010);
  endtask
  task automatic s_force();
    for (int j = 0; j < 4; j++)
    begin
      wr(ADDR_CONTROL, {6'h00, acts[j]});
      wr(ADDR_FORCE, 8'h01);
      settle(2);
      chk({15'h0000, ch_state[0]}, {15'h0000, exp_st[j]});
      chk({15'h0000, pin[0].value}, {15'h0000, acts[j] != ACT_NONE && exp_st[j]});
    end
    chk({14'h0000, match_flag}, 16'h0000);
    @(posedge clk_sys);
    pin_dir <= 2'b11;
    settle(1);
    chk({15'h0000, pin[0].oe}, 16'h0001);
  endtask
  task automatic s_match();
    logic s;
    wr(ADDR_CONTROL, {6'h00, ACT_TOGGLE});
    wr(ADDR_IRQ_ENABLE, 8'h03);
    @(posedge clk_sys);
    run <= 1'b1;
    wait_flag(0);
    chk({14'h0000, irq_req}, 16'h0003);
    chk({15'h0000, ch_state[0]}, 16'h0000);
    @(posedge clk_sys);
    irq_ack <= 2'b01;
    @(posedge clk_sys);
    irq_ack <= 2'b00;
    settle(1);
    chk({14'h0000, match_flag}, 16'h0002);
    wr(ADDR_FLAGS, 8'h00);
    settle(1);
    chk({14'h0000, match_flag}, 16'h0002);
    wr(ADDR_FLAGS, 8'h02);
    settle(1);
    chk({14'h0000, match_flag}, 16'h0000);
    wr(ADDR_CONTROL, {6'h00, ACT_NONE});
    settle(1);
    s = ch_state[0];
    wait_flag(0);
    settle(2);
    chk({15'h0000, ch_state[0]}, {15'h0000, s});
  endtask
  task automatic s_block();
    @(posedge clk_sys);
    run <= 1'b0;
    wr(ADDR_FLAGS, 8'h03);
    @(posedge clk_sys);
    load <= 1'b1;
    load_val <= 16'h0010;
    @(posedge clk_sys);
    load <= 1'b0;
    run <= 1'b1;
    settle(6);
    chk({15'h0000, match_flag[0]}, 16'h0000);
  endtask
  task automatic s_pwm();
    logic [7:0] d;
    @(posedge clk_sys);
    run <= 1'b0;
    wr(ADDR_CONTROL, {WAVE_NORMAL, ACT_SET, ACT_SET});
    wr(ADDR_FORCE, 8'h03);
    wr(ADDR_FLAGS, 8'h03);
    settle(1);
    chk({14'h0000, ch_state}, 16'h0003);
    wr(ADDR_CONTROL, {WAVE_FAST_MATCH, ACT_CLEAR, ACT_NONE});
    wr16(ADDR_MATCH_A_HIGH, 16'h0020);
    rd(ADDR_MATCH_A_LOW, d);
    chk({8'h00, d}, 16'h0020);
    chk(top_value, 16'h0010);
    @(posedge clk_sys);
    run <= 1'b1;
    wait_flag(1);
    chk({15'h0000, ch_state[1]}, 16'h0000);
    wait_top(16'h0020);
    chk(top_value, 16'h0020);
    wr(ADDR_CONTROL, {WAVE_PHASE_MATCH, ACT_NONE, ACT_NONE});
    wr16(ADDR_MATCH_A_HIGH, 16'h0018);
    settle(1);
    chk(top_value, 16'h0020);
    wait_top(16'h0018);
    chk(top_value, 16'h0018);
    wr(ADDR_CONTROL, 8'h00);
    settle(1);
    chk({15'h0000, ch_state[0]}, 16'h0001);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s_regs();
    s_force();
    s_match();
    s_block();
    s_pwm();
    results();
  end
endmodule // tmoc_output_compare_tb

/* File: src/tmoc_output_compare.sv */
// Output compare channels A and B of the 16-bit timer, with register port
`timescale 1ns/100ps
module tmoc_output_compare
  import tmoc_pkg::*;
(
  input  wire logic                        clk_sys_in,
  input  wire logic                        arst_n_in,
  // Register port
  input  wire logic [ADDR_W-1:0]           reg_addr_in,
  input  wire logic [DATA_W-1:0]           reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [DATA_W-1:0]           reg_rdata_out,
  // Counter side
  input  wire logic [CNT_W-1:0]            count_value_in,
  input  wire tmoc_cnt_evt_type            cnt_evt_in,
  output logic      [CNT_W-1:0]            top_value_out,
  output logic                             top_match_out,
  // Interrupt request and service per channel
  output logic      [CHANNELS-1:0]         irq_req_out,
  input  wire logic [CHANNELS-1:0]         irq_ack_in,
  // Port pins
  input  wire logic [CHANNELS-1:0]         pin_direction_bit_in,
  input  wire logic [CHANNELS-1:0]         port_value_in,
  output tmoc_pin_type [CHANNELS-1:0]      pin_out,
  // Internal state for observation
  output logic      [CHANNELS-1:0]         channel_output_state_out,
  output logic      [CHANNELS-1:0]         match_flag_out
);

  typedef enum logic [1:0] {
    WAVE_CLASS_PLAIN,
    WAVE_CLASS_FAST,
    WAVE_CLASS_PHASE,
    WAVE_CLASS_PFC
  } tmoc_wave_class_type;

  logic                   rst_n;
  tmoc_bus_req_type       bus_req;

  // Shared high byte latch and control registers
  logic [DATA_W-1:0]      temp_ff;
  logic [WAVE_W-1:0]      waveform_select_ff;
  logic [ACT_W-1:0]       output_action_select_ff [CHANNELS];
  logic [CHANNELS-1:0]    match_irq_enable_ff;
  logic                   block_ff;
  logic [DATA_W-1:0]      rdata_ff;
  logic [DATA_W-1:0]      nxt_rdata;

  // Per channel state
  logic [CNT_W-1:0]       match_value_ff  [CHANNELS];
  logic [CNT_W-1:0]       match_buffer_ff [CHANNELS];
  logic [CHANNELS-1:0]    match_flag_ff;
  logic [CHANNELS-1:0]    channel_output_state_ff;

  // Decode
  logic                   wr_high_a;
  logic                   wr_low_a;
  logic                   wr_high_b;
  logic                   wr_low_b;
  logic                   wr_control;
  logic                   wr_force;
  logic                   wr_irq_enable;
  logic                   wr_flags;
  logic [CHANNELS-1:0]    wr_low;
  logic                   wr_high_any;
  logic                   is_pwm;
  logic                   buffer_load;
  tmoc_wave_class_type    wave_class;
  logic [CNT_W-1:0]       visible_value [CHANNELS];
  logic [CHANNELS-1:0]    compare_hit;
  logic [CHANNELS-1:0]    match_event;
  logic [CHANNELS-1:0]    force_event;
  logic [CHANNELS-1:0]    nxt_state;
  logic [CHANNELS-1:0]    nxt_flag;
  logic [CNT_W-1:0]       low_write_word;

  tmoc_rst_sync u_rst_sync
  (
    .clk_in    (clk_sys_in),
    .arst_n_in (arst_n_in),
    .rst_n_out (rst_n)
  );

  assign bus_req.addr  = reg_addr_in;
  assign bus_req.wdata = reg_wdata_in;
  assign bus_req.wr    = reg_wr_in;
  assign bus_req.rd    = reg_rd_in;

  assign wr_high_a     = bus_req.wr && (bus_req.addr == ADDR_MATCH_A_HIGH);
  assign wr_low_a      = bus_req.wr && (bus_req.addr == ADDR_MATCH_A_LOW);
  assign wr_high_b     = bus_req.wr && (bus_req.addr == ADDR_MATCH_B_HIGH);
  assign wr_low_b      = bus_req.wr && (bus_req.addr == ADDR_MATCH_B_LOW);
  assign wr_control    = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
  assign wr_force      = bus_req.wr && (bus_req.addr == ADDR_FORCE);
  assign wr_irq_enable = bus_req.wr && (bus_req.addr == ADDR_IRQ_ENABLE);
  assign wr_flags      = bus_req.wr && (bus_req.addr == ADDR_FLAGS);
  assign wr_low        = {wr_low_b, wr_low_a};
  // Either high byte location loads the shared latch
  assign wr_high_any   = wr_high_a || wr_high_b;

  // Latched high byte joins the low byte in one cycle
  assign low_write_word = {temp_ff, bus_req.wdata};

  // Waveform class from the mode code
  always_comb
  begin
    unique case (waveform_select_ff)
      WAVE_NORMAL, WAVE_CTC_MATCH, WAVE_CTC_CAPTURE, WAVE_RESERVED:
        wave_class = WAVE_CLASS_PLAIN;
      WAVE_FAST_8, WAVE_FAST_9, WAVE_FAST_10, WAVE_FAST_CAP, WAVE_FAST_MATCH:
        wave_class = WAVE_CLASS_FAST;
      WAVE_PFC_CAPTURE, WAVE_PFC_MATCH:
        wave_class = WAVE_CLASS_PFC;
      default:
        wave_class = WAVE_CLASS_PHASE;
    endcase
  end

  assign is_pwm = (wave_class != WAVE_CLASS_PLAIN);

  // Phase correct loads at TOP, the other PWM classes at BOTTOM, plain modes never
  assign buffer_load = is_pwm && cnt_evt_in.tick &&
                       ((wave_class == WAVE_CLASS_PHASE) ? cnt_evt_in.at_top
                                                         : cnt_evt_in.at_bottom);

  // Channel A active value is the variable TOP
  assign top_value_out = match_value_ff[0];
  // Blocked match also hides TOP, so the counter runs on to the end
  assign top_match_out = compare_hit[0];

  // Shared high byte latch
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      temp_ff <= BYTE_RST;
    else if (wr_high_any)
      temp_ff <= bus_req.wdata;
  end

  // Control: action bits take effect without buffering
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waveform_select_ff         <= WAVE_RST;
      output_action_select_ff[0] <= ACT_RST;
      output_action_select_ff[1] <= ACT_RST;
    end
    else if (wr_control)
    begin
      waveform_select_ff         <= bus_req.wdata[CTRL_WAVE_LSB +: WAVE_W];
      output_action_select_ff[0] <= bus_req.wdata[CTRL_ACT_A_LSB +: ACT_W];
      output_action_select_ff[1] <= bus_req.wdata[CTRL_ACT_B_LSB +: ACT_W];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      match_irq_enable_ff <= '0;
    else if (wr_irq_enable)
      match_irq_enable_ff <= bus_req.wdata[CHANNELS-1:0];
  end

  // Counter write blocks until the next timer clock cycle ends
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      block_ff <= 1'b0;
    else if (cnt_evt_in.count_write)
      block_ff <= 1'b1;
    else if (cnt_evt_in.tick)
      block_ff <= 1'b0;
  end

  // The software must not write BOTTOM while counting down: that match is lost

  generate
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_channel
      logic [ACT_W-1:0] act;

      assign act = output_action_select_ff[ch];

      // CPU view goes to buffer in PWM modes, else active
      assign visible_value[ch] = is_pwm ? match_buffer_ff[ch] : match_value_ff[ch];

      // Blocked in the timer cycle after a counter write
      assign compare_hit[ch] = (count_value_in == match_value_ff[ch]) &&
                               !block_ff && !cnt_evt_in.count_write;

      assign match_event[ch] = compare_hit[ch] && cnt_evt_in.tick;

      assign force_event[ch] = wr_force && bus_req.wdata[ch] && !is_pwm;

      // Next output state
      always_comb
      begin
        nxt_state[ch] = channel_output_state_ff[ch];
        if (force_event[ch] || (match_event[ch] && !is_pwm))
        begin
          unique case (act)
            ACT_NONE:   nxt_state[ch] = channel_output_state_ff[ch];
            ACT_TOGGLE: nxt_state[ch] = !channel_output_state_ff[ch];
            ACT_CLEAR:  nxt_state[ch] = 1'b0;
            ACT_SET:    nxt_state[ch] = 1'b1;
          endcase
        end
        else if (is_pwm && (act == ACT_CLEAR || act == ACT_SET))
        begin
          // PWM: match drives to the inactive level, BOTTOM restores
          if (match_event[ch])
            nxt_state[ch] = (act == ACT_SET);
          else if (cnt_evt_in.tick && cnt_evt_in.at_bottom)
            nxt_state[ch] = (act == ACT_CLEAR);
        end
      end

      // Set wins over both ways of clearing
      always_comb
      begin
        nxt_flag[ch] = match_flag_ff[ch];
        if (irq_ack_in[ch] || (wr_flags && bus_req.wdata[ch]))
          nxt_flag[ch] = 1'b0;
        if (match_event[ch])
          nxt_flag[ch] = 1'b1;
      end

      // State is kept across mode changes, cleared by reset or by match, force or BOTTOM actions
      always_ff @(posedge clk_sys_in or negedge rst_n)
      begin
        if (!rst_n)
          channel_output_state_ff[ch] <= 1'b0;
        else
          channel_output_state_ff[ch] <= nxt_state[ch];
      end

      always_ff @(posedge clk_sys_in or negedge rst_n)
      begin
        if (!rst_n)
          match_flag_ff[ch] <= 1'b0;
        else
          match_flag_ff[ch] <= nxt_flag[ch];
      end

      // Buffer takes CPU writes in PWM modes
      always_ff @(posedge clk_sys_in or negedge rst_n)
      begin
        if (!rst_n)
          match_buffer_ff[ch] <= MATCH_RST;
        else if (wr_low[ch] && is_pwm)
          match_buffer_ff[ch] <= low_write_word;
      end

      // Active value changes only by CPU write or buffer transfer
      always_ff @(posedge clk_sys_in or negedge rst_n)
      begin
        if (!rst_n)
          match_value_ff[ch] <= MATCH_RST;
        else if (wr_low[ch] && !is_pwm)
          match_value_ff[ch] <= low_write_word;
        else if (buffer_load)
          match_value_ff[ch] <= match_buffer_ff[ch];
      end

      assign irq_req_out[ch] = match_flag_ff[ch] && match_irq_enable_ff[ch];

      // Nonzero action takes over the pin value; direction stays with the port
      assign pin_out[ch].value = (act != ACT_NONE) ? channel_output_state_ff[ch]
                                                   : port_value_in[ch];
      assign pin_out[ch].oe    = pin_direction_bit_in[ch];
    end
  endgenerate

  // Action bits reach only the compare output path, nothing on capture
  // Initialising the state by force in normal mode before enabling the pin

  // Read mux; high byte comes from the register, not the latch
  always_comb
  begin
    nxt_rdata = BYTE_RST;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        ADDR_MATCH_A_LOW:  nxt_rdata = visible_value[0][DATA_W-1:0];
        ADDR_MATCH_A_HIGH: nxt_rdata = visible_value[0][CNT_W-1:DATA_W];
        ADDR_MATCH_B_LOW:  nxt_rdata = visible_value[1][DATA_W-1:0];
        ADDR_MATCH_B_HIGH: nxt_rdata = visible_value[1][CNT_W-1:DATA_W];
        ADDR_CONTROL:
        begin
          nxt_rdata[CTRL_WAVE_LSB +: WAVE_W]  = waveform_select_ff;
          nxt_rdata[CTRL_ACT_A_LSB +: ACT_W]  = output_action_select_ff[0];
          nxt_rdata[CTRL_ACT_B_LSB +: ACT_W]  = output_action_select_ff[1];
        end
        ADDR_IRQ_ENABLE:   nxt_rdata[CHANNELS-1:0] = match_irq_enable_ff;
        ADDR_FLAGS:        nxt_rdata[CHANNELS-1:0] = match_flag_ff;
        default:           nxt_rdata = BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= BYTE_RST;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata_out            = rdata_ff;
  assign channel_output_state_out = channel_output_state_ff;
  assign match_flag_out           = match_flag_ff;

endmodule // tmoc_output_compare

/* File: src/tmoc_pkg.sv */
// Package for the 16-bit timer output compare block: map, fields, codes and carriers
package tmoc_pkg;

  localparam int unsigned CHANNELS     = 2;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 4;

  // Register byte addresses on the 8-bit register port
  localparam logic [3:0] ADDR_MATCH_A_LOW  = 4'h0;
  localparam logic [3:0] ADDR_MATCH_A_HIGH = 4'h1;
  localparam logic [3:0] ADDR_MATCH_B_LOW  = 4'h2;
  localparam logic [3:0] ADDR_MATCH_B_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CONTROL      = 4'h4;
  localparam logic [3:0] ADDR_FORCE        = 4'h5;
  localparam logic [3:0] ADDR_IRQ_ENABLE   = 4'h6;
  localparam logic [3:0] ADDR_FLAGS        = 4'h7;

  // Control register fields
  localparam int unsigned CTRL_ACT_A_LSB   = 0;
  localparam int unsigned CTRL_ACT_B_LSB   = 2;
  localparam int unsigned CTRL_WAVE_LSB    = 4;
  localparam int unsigned ACT_W            = 2;
  localparam int unsigned WAVE_W           = 4;

  // Reset values
  localparam logic [15:0] MATCH_RST        = 16'h0000;
  localparam logic [7:0]  BYTE_RST         = 8'h00;
  localparam logic [1:0]  ACT_RST          = 2'h0;
  localparam logic [3:0]  WAVE_RST         = 4'h0;

  // Waveform select codes that are not PWM
  localparam logic [3:0]  WAVE_NORMAL      = 4'h0;
  localparam logic [3:0]  WAVE_CTC_MATCH   = 4'h4;
  localparam logic [3:0]  WAVE_CTC_CAPTURE = 4'hC;
  localparam logic [3:0]  WAVE_RESERVED    = 4'hD;
  // Phase and frequency correct PWM codes
  localparam logic [3:0]  WAVE_PFC_CAPTURE = 4'h8;
  localparam logic [3:0]  WAVE_PFC_MATCH   = 4'h9;
  // Fast PWM codes
  localparam logic [3:0]  WAVE_FAST_8      = 4'h5;
  localparam logic [3:0]  WAVE_FAST_9      = 4'h6;
  localparam logic [3:0]  WAVE_FAST_10     = 4'h7;
  localparam logic [3:0]  WAVE_FAST_CAP    = 4'hE;
  localparam logic [3:0]  WAVE_FAST_MATCH  = 4'hF;

  // Output action codes
  localparam logic [1:0]  ACT_NONE         = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE       = 2'h1;
  localparam logic [1:0]  ACT_CLEAR        = 2'h2;
  localparam logic [1:0]  ACT_SET          = 2'h3;

  // Events from the counter, all on the system clock
  typedef struct packed {
    logic        tick;         // One timer clock cycle ends this system cycle
    logic        at_top;       // Counter is at TOP this timer cycle
    logic        at_bottom;    // Counter is at BOTTOM this timer cycle
    logic        count_write;  // CPU wrote the counter this system cycle
  } tmoc_cnt_evt_type;

  // Output pin drive of one channel
  typedef struct packed {
    logic        value;
    logic        oe;
  } tmoc_pin_type;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tmoc_bus_req_type;

endpackage

/* File: src/tmoc_rst_sync.sv */
// Reset release synchroniser for the output compare block
`timescale 1ns/100ps
module tmoc_rst_sync
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  output logic      rst_n_out
);

  logic meta_n_ff;
  logic sync_n_ff;

  // Assert at once, release after two edges
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_n_ff <= 1'b0;
      sync_n_ff <= 1'b0;
    end
    else
    begin
      meta_n_ff <= 1'b1;
      sync_n_ff <= meta_n_ff;
    end
  end

  assign rst_n_out = sync_n_ff;

endmodule // tmoc_rst_sync
